// ---- pdhp_pkg.sv ----
// Constants, carriers and states for the parallel handshake port.
// Assumes a single 20 MHz system clock and an Avalon-MM slave host bus.
package pdhp_pkg;

  localparam int CLK_NS   = 50;
  localparam int GAP_NS   = 250;
  localparam int GAP_CYC  = (GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STEP_NS  = 500;
  localparam int STEP_CYC = STEP_NS / CLK_NS;
  localparam int SYNC_W   = 3;

  ////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [4:0] ADDR_CMD  = 5'h00;
  localparam logic [4:0] ADDR_MODE = 5'h04;
  localparam logic [4:0] ADDR_STAT = 5'h08;
  localparam logic [4:0] ADDR_DATA = 5'h0c;
  localparam logic [4:0] ADDR_WCNT = 5'h10;

  localparam int CMD_RST_BIT    = 0;
  localparam int CMD_BRANCH_BIT = 1;
  localparam int CMD_HALT_BIT   = 2;
  localparam int CMD_CLR_BIT    = 3;

  localparam int MODE_IO_BIT = 2;
  localparam int MODE_DC_BIT = 3;
  localparam logic [3:0]  MODE_RST = 4'h3;
  localparam logic [15:0] WCNT_RST = 16'h0001;

  localparam int STAT_RUN_BIT   = 8;
  localparam int STAT_ABORT_BIT = 9;
  localparam int STAT_DONE_BIT  = 10;
  localparam int STAT_FULL_BIT  = 11;

  ////////////////////////////////////////////////////////////////////////
  // Pin carriers, pin levels (negative true)
  typedef struct packed {
    logic ack;
    logic power;
    logic busy;
    logic stop;
    logic spare;
  } pdhp_ctl_s;

  typedef struct packed {
    logic fstb;
    logic step;
    logic eob;
    logic rst;
    logic io;
    logic dc;
  } pdhp_out_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_PWR  = 4'h1,
    ST_BUSY = 4'h2,
    ST_ACK  = 4'h3,
    ST_FILL = 4'h4,
    ST_STEP = 4'h5,
    ST_FSTB = 4'h6,
    ST_DROP = 4'h7,
    ST_END  = 4'h8
  } pdhp_state_e;

endpackage

// ---- pdhp_port.sv ----
// Output handshake sequencer and status path of the parallel port.
// Assumes an Avalon-MM master on MCLK_I and a peripheral on open lines.
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

module pdhp_port (
  input  wire logic              MCLK_I,
  input  wire logic              RST_N_I,
  input  wire logic [4:0]        AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [3:0]        AVS_BYTEENABLE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  output logic [31:0]            AVS_READDATA_O,
  output logic                   AVS_WAITREQUEST_O,
  input  wire pdhp_pkg::pdhp_ctl_s CTL_N_I,
  output pdhp_pkg::pdhp_out_s    CTL_N_O,
  output logic [31:0]            DATA_N_O,
  output logic                   DATA_OE_O
);

  logic [pdhp_pkg::SYNC_W-1:0] sync_q [5];
  logic [4:0]                  filt_q;
  logic [4:0]                  raw_n;
  logic                        ack_a;
  logic                        pwr_a;
  logic                        busy_a;
  logic                        stop_a;
  pdhp_pkg::pdhp_state_e       state_q;
  logic [3:0]                  cnt_q;
  logic                        ready;
  logic [1:0]                  idx_q;
  logic [3:0]                  mode_q;
  logic [15:0]                 wcnt_q;
  logic [15:0]                 words_q;
  logic [31:0]                 data_q;
  logic [31:0]                 buf_q;
  logic                        full_q;
  logic                        halt_q;
  logic                        abort_q;
  logic                        done_q;
  logic                        rd_done_q;
  logic                        soft_rst;
  logic                        wr_acc;
  logic                        load_last;
  logic                        rst_line_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers; a level counts once stages two and three agree
  assign raw_n = CTL_N_I;

  for (genvar g = 0; g < 5; g++) begin : g_sync
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        sync_q[g] <= 3'h7;
        filt_q[g] <= 1'b1;
      end else begin
        sync_q[g] <= {sync_q[g][1:0], raw_n[g]};
        if (sync_q[g][1] == sync_q[g][2]) begin
          filt_q[g] <= sync_q[g][2];
        end
      end
    end
  end

  // Low pin means asserted
  assign ack_a  = ~filt_q[4];
  assign pwr_a  = ~filt_q[3];
  assign busy_a = ~filt_q[2];
  assign stop_a = ~filt_q[1];

  //////////////////////////////////////////////////////////////////////////
  // Avalon slave; reads take one wait cycle so read data come from a flop
  assign AVS_WAITREQUEST_O = (AVS_READ_I & ~rd_done_q) |
                             (AVS_WRITE_I & (AVS_ADDRESS_I == pdhp_pkg::ADDR_DATA) & full_q);
  assign wr_acc   = AVS_WRITE_I & ~AVS_WAITREQUEST_O;
  assign soft_rst = wr_acc & (AVS_ADDRESS_I == pdhp_pkg::ADDR_CMD) &
                    AVS_BYTEENABLE_I[0] & AVS_WRITEDATA_I[pdhp_pkg::CMD_RST_BIT];

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rd_done_q      <= 1'b0;
      AVS_READDATA_O <= 32'h0000_0000;
    end else begin
      rd_done_q <= AVS_READ_I & ~rd_done_q;
      if (AVS_READ_I & ~rd_done_q) begin
        unique case (AVS_ADDRESS_I)
          pdhp_pkg::ADDR_MODE: AVS_READDATA_O <= {28'h0, mode_q};
          pdhp_pkg::ADDR_STAT: AVS_READDATA_O <= {20'h0, full_q, done_q, abort_q,
                                                  (state_q != pdhp_pkg::ST_IDLE), 3'h0, filt_q};
          pdhp_pkg::ADDR_DATA: AVS_READDATA_O <= data_q;
          pdhp_pkg::ADDR_WCNT: AVS_READDATA_O <= {16'h0, wcnt_q};
          default:             AVS_READDATA_O <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mode_q <= pdhp_pkg::MODE_RST;
      wcnt_q <= pdhp_pkg::WCNT_RST;
      data_q <= 32'h0000_0000;
    end else if (soft_rst) begin
      mode_q <= pdhp_pkg::MODE_RST;
    end else if (wr_acc) begin
      if (AVS_ADDRESS_I == pdhp_pkg::ADDR_MODE) begin
        mode_q <= AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[3:0] : mode_q;
      end
      if (AVS_ADDRESS_I == pdhp_pkg::ADDR_WCNT) begin
        wcnt_q <= {AVS_BYTEENABLE_I[1] ? AVS_WRITEDATA_I[15:8] : wcnt_q[15:8],
                   AVS_BYTEENABLE_I[0] ? AVS_WRITEDATA_I[7:0] : wcnt_q[7:0]};
      end
      if (AVS_ADDRESS_I == pdhp_pkg::ADDR_DATA) begin
        data_q <= merge(data_q, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end
    end
  end

  // Writes to a full data register stall, so set and clear never meet
  assign load_last = (state_q == pdhp_pkg::ST_FILL) & ready & full_q & (idx_q == 2'h0);

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      full_q <= 1'b0;
    end else if (soft_rst | load_last) begin
      full_q <= 1'b0;
    end else if (wr_acc & (AVS_ADDRESS_I == pdhp_pkg::ADDR_DATA)) begin
      full_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sticky flags; a hardware set beats a software clear
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      halt_q  <= 1'b0;
      abort_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      if (wr_acc & (AVS_ADDRESS_I == pdhp_pkg::ADDR_CMD) & AVS_BYTEENABLE_I[0] &
          AVS_WRITEDATA_I[pdhp_pkg::CMD_HALT_BIT]) begin
        halt_q <= 1'b1;
      end else if (state_q == pdhp_pkg::ST_IDLE) begin
        halt_q <= 1'b0;
      end
      if ((state_q == pdhp_pkg::ST_PWR) & ready & (~pwr_a | stop_a)) begin
        abort_q <= 1'b1;
      end else if (soft_rst | (wr_acc & (AVS_ADDRESS_I == pdhp_pkg::ADDR_CMD) &
                   AVS_WRITEDATA_I[pdhp_pkg::CMD_CLR_BIT])) begin
        abort_q <= 1'b0;
      end
      if ((state_q == pdhp_pkg::ST_END) & ready) begin
        done_q <= 1'b1;
      end else if (soft_rst | (wr_acc & (AVS_ADDRESS_I == pdhp_pkg::ADDR_CMD) &
                   AVS_WRITEDATA_I[pdhp_pkg::CMD_CLR_BIT])) begin
        done_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output sequencer; cnt_q spaces every step but the start from ST_IDLE by the minimum gap
  assign ready = cnt_q >= 4'(pdhp_pkg::GAP_CYC - 1);

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_q <= pdhp_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      idx_q   <= 2'h0;
      words_q <= 16'h0000;
      buf_q   <= 32'h0000_0000;
    end else if (soft_rst) begin
      state_q <= pdhp_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      buf_q   <= 32'h0000_0000;
    end else begin
      cnt_q <= (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'h1;
      unique case (state_q)
        pdhp_pkg::ST_IDLE: begin
          if (wr_acc & (AVS_ADDRESS_I == pdhp_pkg::ADDR_CMD) & AVS_BYTEENABLE_I[0] &
              AVS_WRITEDATA_I[pdhp_pkg::CMD_BRANCH_BIT]) begin
            state_q <= pdhp_pkg::ST_PWR;
            cnt_q   <= 4'h0;
            words_q <= (wcnt_q == 16'h0) ? 16'h0001 : wcnt_q;
          end
        end
        pdhp_pkg::ST_PWR: begin
          if (ready) begin
            state_q <= (~pwr_a | stop_a) ? pdhp_pkg::ST_END : pdhp_pkg::ST_BUSY;
            cnt_q   <= 4'h0;
          end
        end
        pdhp_pkg::ST_BUSY: begin
          if (ready & ~busy_a) begin
            state_q <= pdhp_pkg::ST_ACK;
            cnt_q   <= 4'h0;
          end
        end
        pdhp_pkg::ST_ACK: begin
          if (ready & ~ack_a) begin
            state_q <= pdhp_pkg::ST_FILL;
            cnt_q   <= 4'h0;
            idx_q   <= mode_q[1:0];
          end
        end
        pdhp_pkg::ST_FILL: begin
          if (ready & full_q) begin
            buf_q[8*idx_q +: 8] <= data_q[8*idx_q +: 8];
            cnt_q <= 4'h0;
            if (idx_q == 2'h0) begin
              state_q <= pdhp_pkg::ST_STEP;
            end else begin
              idx_q <= idx_q - 2'h1;
            end
          end
        end
        pdhp_pkg::ST_STEP: begin
          if (cnt_q == 4'(pdhp_pkg::STEP_CYC - 1)) begin
            state_q <= pdhp_pkg::ST_FSTB;
            cnt_q   <= 4'h0;
          end
        end
        pdhp_pkg::ST_FSTB: begin
          if (ready & ack_a) begin
            state_q <= pdhp_pkg::ST_DROP;
            cnt_q   <= 4'h0;
          end
        end
        pdhp_pkg::ST_DROP: begin
          if (ready) begin
            words_q <= words_q - 16'h1;
            state_q <= ((words_q == 16'h1) | halt_q) ? pdhp_pkg::ST_END : pdhp_pkg::ST_PWR;
            cnt_q   <= 4'h0;
          end
        end
        pdhp_pkg::ST_END: begin
          if (ready) begin
            state_q <= pdhp_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= pdhp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Reset line mirrors the command reset for one gap
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rst_line_q <= 1'b1;
    end else begin
      rst_line_q <= soft_rst | (rst_line_q & ~ready);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin drive, negative true
  assign CTL_N_O.fstb = ~(state_q == pdhp_pkg::ST_FSTB);
  assign CTL_N_O.step = ~(state_q == pdhp_pkg::ST_STEP);
  assign CTL_N_O.eob  = ~(state_q == pdhp_pkg::ST_END);
  assign CTL_N_O.rst  = ~rst_line_q;
  assign CTL_N_O.io   = ~mode_q[pdhp_pkg::MODE_IO_BIT];
  assign CTL_N_O.dc   = ~mode_q[pdhp_pkg::MODE_DC_BIT];
  assign DATA_N_O     = ~buf_q;
  assign DATA_OE_O    = ~mode_q[pdhp_pkg::MODE_IO_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Checks
  logic [3:0] step_len_q;
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      step_len_q <= 4'h0;
    end else begin
      step_len_q <= !CTL_N_O.step ? step_len_q + 4'h1 : 4'h0;
    end
  end

  chk_step_width: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(CTL_N_O.step) |-> step_len_q == 4'(pdhp_pkg::STEP_CYC)) else $error("step pulse width wrong");
  chk_abort_power: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == pdhp_pkg::ST_PWR) && ready && !soft_rst && (!pwr_a || stop_a)
    |=> (state_q == pdhp_pkg::ST_END) && abort_q) else $error("no abort on bad power or stop");
  chk_busy_wait: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == pdhp_pkg::ST_BUSY) && busy_a && !soft_rst |=> state_q == pdhp_pkg::ST_BUSY)
    else $error("busy did not hold the sequence");
  chk_strobe_hold: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    !soft_rst && ($rose(CTL_N_O.step) || ((state_q == pdhp_pkg::ST_FSTB) && !ack_a)) |=> !CTL_N_O.fstb)
    else $error("strobe not held after step");
  chk_strobe_drop: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(CTL_N_O.fstb) |-> $past(ack_a)) else $error("strobe dropped without acknowledge");
  chk_step_gap: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q != $past(state_q)) && ($past(state_q) != pdhp_pkg::ST_IDLE) && !$past(soft_rst)
    |-> $past(cnt_q) >= 4'(pdhp_pkg::GAP_CYC - 1)) else $error("sequence steps too close");
  chk_msb_first: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $rose(state_q == pdhp_pkg::ST_FILL) |-> idx_q == mode_q[1:0]) else $error("fill not msb first");
  chk_status_inv: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    $past(AVS_READ_I) && $past(AVS_ADDRESS_I) == pdhp_pkg::ADDR_STAT && rd_done_q
    |-> AVS_READDATA_O[4:0] == $past(filt_q)) else $error("status not pin level");
  chk_last_word: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (state_q == pdhp_pkg::ST_DROP) && ready && (words_q == 16'h1) && !soft_rst
    |=> !CTL_N_O.eob ##[1:5] state_q == pdhp_pkg::ST_IDLE) else $error("last word did not terminate");
  chk_reset_idle: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    soft_rst |=> (state_q == pdhp_pkg::ST_IDLE) && CTL_N_O.fstb && CTL_N_O.step && CTL_N_O.eob)
    else $error("reset did not idle sequencer");

endmodule

// ---- pdhp_periph.sv ----
// Peripheral model on the cable side of the parallel handshake port.
// Assumes negative true pins, pulled up when released, and one clock shared with the port.
`timescale 1ns/1ps
module pdhp_periph (
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  input  wire pdhp_pkg::pdhp_out_s ctl_n_i,
  input  wire logic [31:0]         data_n_i,
  input  wire logic [7:0]          ack_dly_i,
  input  wire logic [7:0]          busy_cyc_i,
  input  wire logic                power_ok_i,
  input  wire logic                stop_en_i,
  input  wire logic                spare_i,
  output pdhp_pkg::pdhp_ctl_s      ctl_n_o,
  output logic [31:0]              word_o,
  output logic [7:0]               nword_o,
  output logic [7:0]               step_len_o,
  output logic [7:0]               eob_len_o,
  output logic [7:0]               bad_o
);
  logic       ack_n_q;
  logic       stop_n_q;
  logic       step_d1_q;
  logic       eob_d1_q;
  logic [7:0] ack_cnt_q;
  logic [7:0] busy_q;
  logic [7:0] step_q;
  logic [7:0] eob_q;

  // Power held asserted for automatic transfers unless a scenario drops it
  assign ctl_n_o = {ack_n_q, !power_ok_i, busy_q == 8'h00, stop_n_q, !spare_i};

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_n_q    <= 1'h1;
      stop_n_q   <= 1'h1;
      step_d1_q  <= 1'h1;
      eob_d1_q   <= 1'h1;
      ack_cnt_q  <= 8'h00;
      busy_q     <= 8'h00;
      step_q     <= 8'h00;
      eob_q      <= 8'h00;
      word_o     <= 32'h0;
      nword_o    <= 8'h00;
      step_len_o <= 8'h00;
      eob_len_o  <= 8'h00;
      bad_o      <= 8'h00;
    end else begin
      step_d1_q <= ctl_n_i.step;
      eob_d1_q  <= ctl_n_i.eob;
      if (!ctl_n_i.eob) begin
        stop_n_q <= 1'h1;
      end
      // Acknowledge answers the strobe after a chosen delay, drops with it
      if (!ctl_n_i.fstb) begin
        if (ack_cnt_q == ack_dly_i) begin
          ack_n_q <= 1'h0;
          if (ack_n_q && stop_en_i) begin
            stop_n_q <= 1'h0;
          end
        end else begin
          ack_cnt_q <= ack_cnt_q + 8'h01;
        end
      end else begin
        ack_cnt_q <= 8'h00;
        ack_n_q   <= 1'h1;
      end
      // Busy only ever rises in answer to the step pulse
      if (!ctl_n_i.step && step_d1_q) begin
        busy_q  <= busy_cyc_i;
        word_o  <= ~data_n_i;
        nword_o <= nword_o + 8'h01;
        if (busy_q != 8'h00 || !ack_n_q) begin
          bad_o <= bad_o + 8'h01;
        end
      end else if (busy_q != 8'h00) begin
        busy_q <= busy_q - 8'h01;
      end
      if (!ctl_n_i.step) begin
        step_q <= step_d1_q ? 8'h01 : step_q + 8'h01;
        if (!ctl_n_i.fstb) begin
          bad_o <= bad_o + 8'h01;
        end
      end else if (!step_d1_q) begin
        step_len_o <= step_q;
      end
      if (!ctl_n_i.eob) begin
        eob_q <= eob_d1_q ? 8'h01 : eob_q + 8'h01;
      end else if (!eob_d1_q) begin
        eob_len_o <= eob_q;
      end
    end
  end
endmodule

// ---- tb_parallel_device_handshake_port.sv ----
// Self-checking testbench for the parallel handshake port.
// Assumes the peripheral model pdhp_periph on the cable side.
`timescale 1ns/1ps
module tb_parallel_device_handshake_port;
  logic                clk;
  logic                rst_n;
  logic [4:0]          addr;
  logic                rd;
  logic                wr;
  logic [31:0]         wdata;
  logic [31:0]         rdata;
  logic                waitreq;
  pdhp_pkg::pdhp_ctl_s ctl_n;
  pdhp_pkg::pdhp_out_s out_n;
  logic [31:0]         data_n;
  logic                oe;
  logic [7:0]          ack_dly;
  logic [7:0]          busy_cyc;
  logic                power_ok;
  logic                stop_en;
  logic                spare;
  logic [31:0]         word;
  logic [7:0]          nword;
  logic [7:0]          step_len;
  logic [7:0]          eob_len;
  logic [7:0]          bad;
  logic [31:0]         q;
  int                  error_cnt;
  int                  n_compared;

  pdhp_port uut (.MCLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_BYTEENABLE_I(4'hf), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
    .CTL_N_I(ctl_n), .CTL_N_O(out_n), .DATA_N_O(data_n), .DATA_OE_O(oe));
  pdhp_periph peri (.clk_i(clk), .rst_n_i(rst_n), .ctl_n_i(out_n), .data_n_i(data_n), .ack_dly_i(ack_dly),
    .busy_cyc_i(busy_cyc), .power_ok_i(power_ok), .stop_en_i(stop_en), .spare_i(spare), .ctl_n_o(ctl_n),
    .word_o(word), .nword_o(nword), .step_len_o(step_len), .eob_len_o(eob_len), .bad_o(bad));

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic timeout(input string what);
    error_cnt++;
    $display("mismatch %s expected finish seen timeout", what);
    stop_test();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkb(input string what, input logic exp, input logic got);
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  // Holds the request until waitrequest is seen low at an edge; a stalled data write may wait long
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= w;
    rd    <= !w;
    for (i = 0; i < 3000; i++) begin
      @(posedge clk);
      if (waitreq === 1'h0) break;
    end
    r = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
    if (i == 3000) timeout("waitrequest");
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    bus(1'h1, a, d, q);
  endtask
  task automatic rd_reg(input logic [4:0] a);
    bus(1'h0, a, 32'h0, q);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 500; i++) begin
      rd_reg(pdhp_pkg::ADDR_STAT);
      if (q[pdhp_pkg::STAT_RUN_BIT] === 1'h0 &&
          (q[pdhp_pkg::STAT_DONE_BIT] | q[pdhp_pkg::STAT_ABORT_BIT]) === 1'h1) break;
    end
    if (i == 500) timeout("sequence");
  endtask
  task automatic wait_words(input logic [7:0] n);
    int i;
    for (i = 0; i < 3000 && nword !== n; i++) @(posedge clk);
    if (i == 3000) timeout("words");
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge clk);
    chk("idle pins", 32'h7, {29'h0, out_n.fstb, out_n.step, out_n.eob});
    chk("data pins", 32'hffffffff, data_n);
    chkb("data enable", 1'h1, oe);
    rd_reg(pdhp_pkg::ADDR_MODE);
    chk("mode", 32'h3, q);
    rd_reg(pdhp_pkg::ADDR_WCNT);
    chk("wcnt", 32'h1, q);
    rd_reg(5'h14);
    chk("unmapped", 32'h0, q);
    rd_reg(pdhp_pkg::ADDR_STAT);
    chk("status lines", 32'h17, {27'h0, q[4:0]});
  endtask
  task automatic t_status();
    logic [1:0] pat;
    for (int k = 0; k < 4; k++) begin
      pat = k[1:0];
      power_ok <= pat[1];
      spare    <= pat[0];
      repeat (8) @(posedge clk);
      rd_reg(pdhp_pkg::ADDR_STAT);
      chk("status pins", {27'h0, 1'h1, !pat[1], 2'h3, !pat[0]}, {27'h0, q[4:0]});
    end
  endtask
  task automatic t_xfer32();
    spare <= 1'h1;
    busy_cyc <= 8'h28;
    wr_reg(pdhp_pkg::ADDR_WCNT, 32'h2);
    wr_reg(pdhp_pkg::ADDR_DATA, 32'h8421c3a5);
    wr_reg(pdhp_pkg::ADDR_CMD, 32'h2);
    wr_reg(pdhp_pkg::ADDR_DATA, 32'h5a6b7c0d);
    wait_words(8'h01);
    chk("first word", 32'h8421c3a5, word);
    wait_idle();
    chk("word count", 32'h2, {24'h0, nword});
    chk("last word", 32'h5a6b7c0d, word);
    chkb("done", 1'h1, q[pdhp_pkg::STAT_DONE_BIT]);
    chkb("abort", 1'h0, q[pdhp_pkg::STAT_ABORT_BIT]);
    chk("step length", pdhp_pkg::STEP_CYC, {24'h0, step_len});
    chk("end length", 32'h5, {24'h0, eob_len});
    chk("order faults", 32'h0, {24'h0, bad});
    chk("held data", 32'ha59483f2, data_n);
    wr_reg(pdhp_pkg::ADDR_CMD, 32'h8);
  endtask
  task automatic t_xfer8();
    wr_reg(pdhp_pkg::ADDR_MODE, 32'hc);
    @(negedge clk);
    chk("mode pins", 32'h0, {29'h0, out_n.io, out_n.dc, oe});
    wr_reg(pdhp_pkg::ADDR_MODE, 32'h0);
    // Halt during the first of three words must end after that word
    wr_reg(pdhp_pkg::ADDR_WCNT, 32'h3);
    wr_reg(pdhp_pkg::ADDR_DATA, 32'h000000e7);
    wr_reg(pdhp_pkg::ADDR_CMD, 32'h2);
    wr_reg(pdhp_pkg::ADDR_CMD, 32'h4);
    wait_idle();
    chk("byte word", 32'h5a6b7ce7, word);
    chk("halt words", 32'h3, {24'h0, nword});
    chkb("halt done", 1'h1, q[pdhp_pkg::STAT_DONE_BIT]);
    wr_reg(pdhp_pkg::ADDR_CMD, 32'h8);
    rd_reg(pdhp_pkg::ADDR_STAT);
    chkb("done cleared", 1'h0, q[pdhp_pkg::STAT_DONE_BIT]);
  endtask
  task automatic t_stop();
    wr_reg(pdhp_pkg::ADDR_MODE, 32'h3);
    wr_reg(pdhp_pkg::ADDR_WCNT, 32'h3);
    stop_en <= 1'h1;
    wr_reg(pdhp_pkg::ADDR_DATA, 32'h0f1e2d3c);
    wr_reg(pdhp_pkg::ADDR_CMD, 32'h2);
    wait_idle();
    stop_en <= 1'h0;
    chk("words before stop", 32'h4, {24'h0, nword});
    chkb("stop abort", 1'h1, q[pdhp_pkg::STAT_ABORT_BIT]);
    chk("end on abort", 32'h5, {24'h0, eob_len});
    wr_reg(pdhp_pkg::ADDR_CMD, 32'h8);
  endtask
  task automatic t_power();
    power_ok <= 1'h0;
    repeat (8) @(posedge clk);
    wr_reg(pdhp_pkg::ADDR_DATA, 32'h11223344);
    wr_reg(pdhp_pkg::ADDR_CMD, 32'h2);
    wait_idle();
    chk("no words", 32'h4, {24'h0, nword});
    chkb("power abort", 1'h1, q[pdhp_pkg::STAT_ABORT_BIT]);
    chkb("still full", 1'h1, q[pdhp_pkg::STAT_FULL_BIT]);
    power_ok <= 1'h1;
    wr_reg(pdhp_pkg::ADDR_CMD, 32'h1);
    repeat (2) @(negedge clk);
    chkb("reset pin", 1'h0, out_n.rst);
    rd_reg(pdhp_pkg::ADDR_STAT);
    chk("soft reset status", 32'h0, {20'h0, q[11:8], 8'h0});
    rd_reg(pdhp_pkg::ADDR_MODE);
    chk("soft reset mode", 32'h3, q);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial begin
    {rst_n, rd, wr, stop_en, spare} = 5'h0;
    {addr, wdata} = 37'h0;
    ack_dly   = 8'h08;
    busy_cyc  = 8'h00;
    power_ok  = 1'h1;
    error_cnt = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_status();
    t_xfer32();
    t_xfer8();
    t_stop();
    t_power();
    stop_test();
  end
endmodule
